//--- slbc_pkg.sv
package slbc_pkg;
    // ------------------------------------------------------------
    // register map (apb byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SLBC_OFS_CTRL = 8'h00;
    localparam logic [7:0] SLBC_OFS_CODE = 8'h04;
    localparam logic [7:0] SLBC_OFS_OVR = 8'h08;
    localparam logic [7:0] SLBC_OFS_USER = 8'h0c;
    localparam logic [7:0] SLBC_OFS_LEDS = 8'h10;
    localparam logic [7:0] SLBC_OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] SLBC_OFS_IRQ_MASK = 8'h18;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SLBC_BIT_YEL = 0;
    localparam int SLBC_BIT_GRN = 1;
    localparam int SLBC_BIT_RED = 2;
    localparam int SLBC_CTRL_READY = 0;
    localparam int SLBC_CTRL_RUN = 1;
    localparam int SLBC_CTRL_FORCED = 2;
    localparam int SLBC_CODE_ALM_POS = 0;
    localparam int SLBC_CODE_FLT_POS = 16;
    localparam int SLBC_EV_ALARM = 0;
    localparam int SLBC_EV_FAULT = 1;
    localparam int SLBC_EV_FORCED = 2;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] SLBC_RST_OVR = 3'h0;
    localparam logic [2:0] SLBC_RST_CTRL = 3'h0;
    localparam logic [2:0] SLBC_RST_IRQ = 3'h0;
    // ------------------------------------------------------------
    // blink codes and timing
    // ------------------------------------------------------------
    localparam logic [3:0] SLBC_CODE_NONE = 4'h0;
    localparam logic [3:0] SLBC_CODE_FORCED = 4'ha;
    localparam logic [3:0] SLBC_CODE_OTHER = 4'ha;
    localparam int SLBC_CLK_MHZ = 250;
    localparam int SLBC_PHASE_MS = 250;
    localparam int SLBC_PAUSE_MS = 1000;
    localparam int SLBC_PHASE_CYC = SLBC_PHASE_MS * 1000 * SLBC_CLK_MHZ;
    localparam int SLBC_PAUSE_CYC = SLBC_PAUSE_MS * 1000 * SLBC_CLK_MHZ;
    typedef enum logic [1:0] {
        SLBC_IDLE = 2'b00,
        SLBC_ON = 2'b01,
        SLBC_OFF = 2'b11,
        SLBC_PAUSE = 2'b10
    } slbc_state_e;
endpackage : slbc_pkg

//--- slbc_top.sv
`timescale 1ns/10ps
// Overview of operation
// - ready and idle: green steady, others dark
// - running: green blinks, others normally dark
// - alarm: yellow blinks alarm code
// - forced configuration while running: yellow blinks code ten
// - fault: red blinks code, green yellow dark
// - codes 1, 2, 4 from their numbers
// - codes 5, 6; others give ten
// - communication alarms and faults give code 3
// - present indicator states readable by software
// - user writes honoured only where overridden
// - override bits: 0 yellow, 1 green, 2 red
module slbc_code_map
    import slbc_pkg::*;
(
    input wire logic is_fault,
    input wire logic [15:0] num,
    output logic [3:0] code
);
    always_comb begin
        code = SLBC_CODE_OTHER;
        if (!is_fault) begin
            case (num)
                16'd51: code = 4'h1;
                16'd46, 16'd47: code = 4'h2;
                16'd128, 16'd135, 16'd139, 16'd140, 16'd700: code = 4'h3;
                16'd90: code = 4'h4;
                default: code = SLBC_CODE_OTHER;
            endcase
        end else begin
            case (num)
                16'd51, 16'd68, 16'd78: code = 4'h1;
                16'd72, 16'd48: code = 4'h2;
                16'd31, 16'd228, 16'd700: code = 4'h3;
                16'd91: code = 4'h4;
                16'd70, 16'd74: code = 4'h5;
                16'd22, 16'd21: code = 4'h6;
                default: begin
                    if (num >= 16'd233 && num <= 16'd240) begin
                        code = 4'h3;
                    end else begin
                        code = SLBC_CODE_OTHER;
                    end
                end
            endcase
        end
    end
endmodule : slbc_code_map

module slbc_blinker
    import slbc_pkg::*;
#(
    parameter int PHASE_CYC = SLBC_PHASE_CYC,
    parameter int PAUSE_CYC = SLBC_PAUSE_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [3:0] code,
    output logic lit
);
    slbc_state_e state_q;
    logic [31:0] tmr_q;
    logic [3:0] cnt_q;
    logic [3:0] code_q;
    // each timer load is count minus one, so a phase lasts exactly count cycles
    // ------------------------------------------------------------
    // pulse train: n on/off pairs then pause
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= SLBC_IDLE;
            tmr_q <= 32'h0;
            cnt_q <= 4'h0;
            code_q <= 4'h0;
        end else if (ce) begin
            case (state_q)
                SLBC_IDLE: begin
                    if (code != SLBC_CODE_NONE) begin
                        // code latched per sequence so a change never truncates a count
                        code_q <= code;
                        cnt_q <= 4'h1;
                        tmr_q <= 32'(PHASE_CYC - 1);
                        state_q <= SLBC_ON;
                    end
                end
                SLBC_ON: begin
                    if (tmr_q == 32'h0) begin
                        tmr_q <= 32'(PHASE_CYC - 1);
                        state_q <= SLBC_OFF;
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                SLBC_OFF: begin
                    if (tmr_q != 32'h0) begin
                        tmr_q <= tmr_q - 32'h1;
                    end else if (cnt_q < code_q) begin
                        cnt_q <= cnt_q + 4'h1;
                        tmr_q <= 32'(PHASE_CYC - 1);
                        state_q <= SLBC_ON;
                    end else begin
                        tmr_q <= 32'(PAUSE_CYC - 1);
                        state_q <= SLBC_PAUSE;
                    end
                end
                SLBC_PAUSE: begin
                    if (tmr_q == 32'h0) begin
                        state_q <= SLBC_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                default: state_q <= SLBC_IDLE;
            endcase
        end
    end
    assign lit = (state_q == SLBC_ON);
endmodule : slbc_blinker

module slbc_top
    import slbc_pkg::*;
#(
    parameter int PHASE_CYC = SLBC_PHASE_CYC,
    parameter int PAUSE_CYC = SLBC_PAUSE_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic led_red,
    output logic led_green,
    output logic led_yellow,
    output logic irq
);
    logic [2:0] ctrl_q;
    logic alm_act_q;
    logic flt_act_q;
    logic [15:0] alm_num_q;
    logic [15:0] flt_num_q;
    logic [2:0] ovr_q;
    logic [2:0] user_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic [2:0] ev_q;
    logic [3:0] alm_code;
    logic [3:0] flt_code;
    logic [3:0] yel_code;
    logic [3:0] red_code;
    logic [3:0] grn_code;
    logic yel_lit;
    logic red_lit;
    logic grn_lit;
    logic [2:0] led_d;
    logic [2:0] ev_now;
    logic wr;
    logic rd;
    logic [31:0] rdata_d;
    logic addr_ok;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // ------------------------------------------------------------
    // apb write side
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= SLBC_RST_CTRL;
            alm_act_q <= 1'b0;
            flt_act_q <= 1'b0;
            alm_num_q <= 16'h0;
            flt_num_q <= 16'h0;
            ovr_q <= SLBC_RST_OVR;
            user_q <= 3'h0;
            mask_q <= SLBC_RST_IRQ;
        end else if (ce && wr) begin
            case (paddr)
                SLBC_OFS_CTRL: ctrl_q <= pwdata[2:0];
                SLBC_OFS_CODE: begin
                    alm_num_q <= {1'b0, pwdata[SLBC_CODE_ALM_POS +: 15]};
                    alm_act_q <= pwdata[SLBC_CODE_ALM_POS + 15];
                    flt_num_q <= {1'b0, pwdata[SLBC_CODE_FLT_POS +: 15]};
                    flt_act_q <= pwdata[SLBC_CODE_FLT_POS + 15];
                end
                SLBC_OFS_OVR: ovr_q <= pwdata[2:0];
                SLBC_OFS_USER: user_q <= pwdata[2:0];
                SLBC_OFS_IRQ_MASK: mask_q <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // code selection and blinkers
    // ------------------------------------------------------------
    slbc_code_map u_alm_map (.is_fault(1'b0), .num(alm_num_q), .code(alm_code));
    slbc_code_map u_flt_map (.is_fault(1'b1), .num(flt_num_q), .code(flt_code));

    always_comb begin
        red_code = flt_act_q ? flt_code : SLBC_CODE_NONE;
        yel_code = SLBC_CODE_NONE;
        if (!flt_act_q) begin
            if (alm_act_q) begin
                yel_code = alm_code;
            end else if (ctrl_q[SLBC_CTRL_FORCED] && ctrl_q[SLBC_CTRL_RUN]) begin
                yel_code = SLBC_CODE_FORCED;
            end
        end
        // running shown as a single-pulse train
        grn_code = 4'h1;
    end

    slbc_blinker #(.PHASE_CYC(PHASE_CYC), .PAUSE_CYC(PHASE_CYC)) u_grn (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .code(grn_code), .lit(grn_lit)
    );
    slbc_blinker #(.PHASE_CYC(PHASE_CYC), .PAUSE_CYC(PAUSE_CYC)) u_yel (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .code(yel_code), .lit(yel_lit)
    );
    slbc_blinker #(.PHASE_CYC(PHASE_CYC), .PAUSE_CYC(PAUSE_CYC)) u_red (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .code(red_code), .lit(red_lit)
    );

    always_comb begin
        led_d = 3'h0;
        if (!flt_act_q) begin
            if (ctrl_q[SLBC_CTRL_RUN]) begin
                led_d[SLBC_BIT_GRN] = grn_lit;
            end else if (ctrl_q[SLBC_CTRL_READY]) begin
                led_d[SLBC_BIT_GRN] = 1'b1;
            end
            led_d[SLBC_BIT_YEL] = yel_lit;
        end else begin
            led_d[SLBC_BIT_RED] = red_lit;
        end
        for (int i = 0; i < 3; i++) begin
            if (ovr_q[i]) begin
                led_d[i] = user_q[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            led_yellow <= 1'b0;
            led_green <= 1'b0;
            led_red <= 1'b0;
        end else if (ce) begin
            led_yellow <= led_d[SLBC_BIT_YEL];
            led_green <= led_d[SLBC_BIT_GRN];
            led_red <= led_d[SLBC_BIT_RED];
        end
    end

    // ------------------------------------------------------------
    // interrupts: rising edges of alarm, fault, forced
    // ------------------------------------------------------------
    assign ev_now = {ctrl_q[SLBC_CTRL_FORCED], flt_act_q, alm_act_q};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ev_q <= 3'h0;
            stat_q <= SLBC_RST_IRQ;
            irq <= 1'b0;
        end else if (ce) begin
            ev_q <= ev_now;
            // set wins over a same-cycle write-one-to-clear
            if (wr && paddr == SLBC_OFS_IRQ_STAT) begin
                stat_q <= (stat_q & ~pwdata[2:0]) | (ev_now & ~ev_q);
            end else begin
                stat_q <= stat_q | (ev_now & ~ev_q);
            end
            irq <= |(stat_q & mask_q);
        end
    end

    // ------------------------------------------------------------
    // apb read side: data registered in setup, answer in access
    // ------------------------------------------------------------
    always_comb begin
        addr_ok = 1'b1;
        rdata_d = 32'h0;
        case (paddr)
            SLBC_OFS_CTRL: rdata_d = {29'h0, ctrl_q};
            SLBC_OFS_CODE: rdata_d = {flt_act_q, flt_num_q[14:0], alm_act_q, alm_num_q[14:0]};
            SLBC_OFS_OVR: rdata_d = {29'h0, ovr_q};
            SLBC_OFS_USER: rdata_d = {29'h0, user_q};
            SLBC_OFS_LEDS: rdata_d = {29'h0, led_red, led_green, led_yellow};
            SLBC_OFS_IRQ_STAT: rdata_d = {29'h0, stat_q};
            SLBC_OFS_IRQ_MASK: rdata_d = {29'h0, mask_q};
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (rd) begin
                prdata <= rdata_d;
            end
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end
endmodule : slbc_top

//--- slbc_led_watch.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// indicator observer: counts pulses of one lamp between pauses
// ------------------------------------------------------------
module slbc_led_watch #(
    parameter int GAP = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic lit,
    output logic [3:0] burst,
    output logic [15:0] rises
);
    logic lit_q;
    logic [3:0] cnt_q;
    logic [7:0] dark_q;
    // gap longer than one off phase marks the end of a train
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lit_q <= 1'b0;
            cnt_q <= 4'h0;
            dark_q <= 8'h00;
            burst <= 4'h0;
            rises <= 16'h0000;
        end else begin
            lit_q <= lit;
            dark_q <= lit ? 8'h00 : (dark_q == 8'hff ? dark_q : dark_q + 8'h01);
            if (lit && !lit_q) begin
                cnt_q <= cnt_q + 4'h1;
                rises <= rises + 16'h0001;
            end
            if (!lit && dark_q == GAP && cnt_q != 4'h0) begin
                burst <= cnt_q;
                cnt_q <= 4'h0;
            end
        end
    end
endmodule : slbc_led_watch

//--- slbc_top_assertions.sv
`timescale 1ns/10ps
module slbc_chk
    import slbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic led_red,
    input wire logic led_green,
    input wire logic led_yellow,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // shadow of software-written control
    // ------------------------------------------------------------
    logic [2:0] ovr_q;
    logic [2:0] usr_q;
    logic [2:0] msk_q;
    logic flt_q;
    wire logic setup = psel && !penable && ce;
    wire logic bad_adr = paddr[1:0] != 2'h0 || paddr > SLBC_OFS_IRQ_MASK;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ovr_q <= 3'h0;
            usr_q <= 3'h0;
            msk_q <= 3'h0;
            flt_q <= 1'b0;
        end else if (ce && psel && penable && pready && pwrite && !pslverr) begin
            if (paddr == SLBC_OFS_OVR) ovr_q <= pwdata[2:0];
            if (paddr == SLBC_OFS_USER) usr_q <= pwdata[2:0];
            if (paddr == SLBC_OFS_IRQ_MASK) msk_q <= pwdata[2:0];
            if (paddr == SLBC_OFS_CODE) flt_q <= pwdata[31];
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_pready_answer: assert property (setup |=> pready)
        else $error("no answer after setup");
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_slverr_map: assert property (setup && bad_adr |=> pslverr && pready)
        else $error("unmapped access not refused");
    a_ovr_yel: assert property (ovr_q[0] |=> led_yellow == $past(usr_q[0]))
        else $error("yellow ignores user value");
    a_ovr_grn: assert property (ovr_q[1] |=> led_green == $past(usr_q[1]))
        else $error("green ignores user value");
    a_ovr_red: assert property (ovr_q[2] |=> led_red == $past(usr_q[2]))
        else $error("red ignores user value");
    a_fault_grn: assert property (flt_q && !ovr_q[1] |=> !led_green)
        else $error("green lit in fault");
    a_fault_yel: assert property (flt_q && !ovr_q[0] |=> !led_yellow)
        else $error("yellow lit in fault");
    a_irq_masked: assert property (msk_q == 3'h0 |=> !irq)
        else $error("irq with all masked");
    c_fault_red: cover property (flt_q && led_red);
    c_all_ovr: cover property (ovr_q == 3'h7);
    c_refused: cover property (setup && bad_adr);
endmodule : slbc_chk

bind slbc_top slbc_chk chk_u (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .led_red(led_red),
    .led_green(led_green),
    .led_yellow(led_yellow),
    .irq(irq)
);

//--- testbench.sv
`timescale 1ns/10ps
module testbench
    import slbc_pkg::*;
;
    localparam int PH = 4;
    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat, prdata;
    logic pready, pslverr, led_red, led_green, led_yellow, irq;
    logic [3:0] b_r, b_g, b_y;
    logic [15:0] n_r, n_g, n_y;
    int bad_count = 0, checked = 0;
    int anum[10] = '{51, 46, 47, 128, 135, 139, 140, 700, 90, 999};
    int acod[10] = '{1, 2, 2, 3, 3, 3, 3, 3, 4, 10};
    int fnum[16] = '{51, 68, 78, 72, 48, 31, 228, 233, 240, 700, 91, 70, 74, 22, 21, 5};
    int fcod[16] = '{1, 1, 1, 2, 2, 3, 3, 3, 3, 3, 4, 5, 5, 6, 6, 10};
    initial forever #2 mclk = ~mclk;
    // short phase and pause keep a code-ten train under a hundred cycles
    slbc_top #(.PHASE_CYC(PH), .PAUSE_CYC(16)) dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .led_red(led_red),
        .led_green(led_green), .led_yellow(led_yellow), .irq(irq));
    slbc_led_watch #(.GAP(2 * PH)) w_r (.mclk(mclk), .rst_n(rst_n), .lit(led_red), .burst(b_r), .rises(n_r));
    slbc_led_watch #(.GAP(2 * PH)) w_g (.mclk(mclk), .rst_n(rst_n), .lit(led_green), .burst(b_g), .rises(n_g));
    slbc_led_watch #(.GAP(2 * PH)) w_y (.mclk(mclk), .rst_n(rst_n), .lit(led_yellow), .burst(b_y), .rises(n_y));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task wcy(input int n);
        repeat (n) @(posedge mclk);
    endtask : wcy
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) bad_count++;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check("reg", rdat, e);
    endtask : rdc
    function logic [31:0] leds();
        return {29'h0, led_red, led_green, led_yellow};
    endfunction : leds
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        check("pins", leds(), 32'h0);
        rdc(SLBC_OFS_OVR, 32'h0);
        rdc(SLBC_OFS_CTRL, 32'h0);
        rdc(SLBC_OFS_IRQ_MASK, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        check("rd_data", rdat, 32'h0);
        check("rd_err", err, 1'b1);
        apb(1'b1, 8'h02, 32'h7);
        check("wr_err", err, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task t_ready;
        logic [15:0] g0;
        logic [31:0] l0;
        wr(SLBC_OFS_CTRL, 32'h1);
        wcy(8);
        g0 = n_g;
        wcy(40);
        check("pins", leds(), 32'h2);
        check("grn_rises", n_g, g0);
        rdc(SLBC_OFS_LEDS, 32'h2);
        wr(SLBC_OFS_CTRL, 32'h3);
        g0 = n_g;
        wcy(100);
        check("grn_blink", n_g - g0 > 16'h3, 1'b1);
        check("yel_red", {n_y, n_r}, 32'h0);
        // clock enable low must freeze the blinking lamp
        ce <= 1'b0;
        wcy(1);
        g0 = n_g;
        l0 = leds();
        wcy(40);
        check("ce_rises", n_g, g0);
        check("ce_pins", leds(), l0);
        ce <= 1'b1;
        $display("test ready and run done");
    endtask : t_ready
    task t_codes;
        logic [15:0] g0, y0;
        wr(SLBC_OFS_CTRL, 32'h7);
        wcy(250);
        check("yel_code", b_y, 4'ha);
        for (int i = 0; i < 10; i++) begin
            wr(SLBC_OFS_CODE, 32'h8000 | anum[i]);
            wcy(250);
            check("yel_code", b_y, acod[i]);
            check("red_rises", n_r, 16'h0);
        end
        // alarm 51 stays raised beside every fault
        for (int i = 0; i < 16; i++) begin
            wr(SLBC_OFS_CODE, 32'h80008033 | (fnum[i] << 16));
            wcy(250);
            check("red_code", b_r, fcod[i]);
            g0 = n_g;
            y0 = n_y;
            wcy(60);
            check("dark_cnt", {n_g, n_y}, {g0, y0});
            check("dark_pins", {led_green, led_yellow}, 2'b00);
        end
        $display("test codes done");
    endtask : t_codes
    task t_ovr;
        logic [31:0] e;
        wr(SLBC_OFS_CODE, 32'h0);
        wr(SLBC_OFS_CTRL, 32'h1);
        wr(SLBC_OFS_USER, 32'h5);
        wcy(120);
        for (int i = 0; i < 8; i++) begin
            wr(SLBC_OFS_OVR, i);
            wcy(4);
            e = (i & 5) | (~i & 2);
            check("pins", leds(), e);
            rdc(SLBC_OFS_LEDS, e);
        end
        $display("test override done");
    endtask : t_ovr
    task t_irq;
        wr(SLBC_OFS_OVR, 32'h0);
        wr(SLBC_OFS_IRQ_STAT, 32'h7);
        wr(SLBC_OFS_IRQ_MASK, 32'h1);
        wr(SLBC_OFS_CODE, 32'h8033);
        wcy(4);
        check("irq", irq, 1'b1);
        rdc(SLBC_OFS_IRQ_STAT, 32'h1);
        wr(SLBC_OFS_IRQ_STAT, 32'h1);
        wcy(4);
        check("irq", irq, 1'b0);
        wr(SLBC_OFS_CODE, 32'h80338033);
        wcy(4);
        check("irq", irq, 1'b0);
        rdc(SLBC_OFS_IRQ_STAT, 32'h2);
        wr(SLBC_OFS_IRQ_MASK, 32'h3);
        wcy(4);
        check("irq", irq, 1'b1);
        $display("test interrupt done");
    endtask : t_irq
    task wrap_up;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_ready();
        t_codes();
        t_ovr();
        t_irq();
        wrap_up();
    end
endmodule : testbench
